// [hw/tcvs_top.sv]
// channel value registers, per-channel flag/enable and combined status
// assumes the timer core supplies mode, events and update points on mclk
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tcvs_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tcvs_pkg::tcvs_timer_in_t timer_in,
  output tcvs_pkg::tcvs_timer_out_t timer_out,
  output logic irq
);
  import tcvs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] active_q [tcvs_nch];
  logic [15:0] buffer_q [tcvs_nch];
  logic [tcvs_nch-1:0] pend_q;
  logic [tcvs_nch-1:0] flag_q;
  logic [tcvs_nch-1:0] ie_q;
  logic [tcvs_nch-1:0] istat_q;
  logic [tcvs_nch-1:0] imask_q;
  logic [tcvs_nch-1:0] flag_prev_q;
  logic [tcvs_nch-1:0] wr_val;
  logic [tcvs_nch-1:0] wr_ctl;
  logic [tcvs_nch-1:0] clr_req;
  logic [tcvs_nch-1:0] flag_rise;
  logic wr_sts;
  logic wr_ist;
  logic wr_imk;
  logic access;
  logic mapped;
  logic [31:0] rd_d;

  // one-cycle access strobe at the start of the two-cycle access phase
  assign access = psel && penable && !pready;

  always_comb begin
    wr_val = '0;
    wr_ctl = '0;
    mapped = 1'b0;
    rd_d = 32'h00000000;
    for (int i = 0; i < tcvs_nch; i++) begin
      if (paddr == 12'(tcvs_off_value0 + 12'(i) * tcvs_off_value_step)) begin
        mapped = 1'b1;
        wr_val[i] = access && pwrite;
        rd_d = {16'h0000, active_q[i]};
      end
      if (paddr == 12'(tcvs_off_ctrl0 + 12'(i) * tcvs_off_value_step)) begin
        mapped = 1'b1;
        wr_ctl[i] = access && pwrite;
        rd_d = 32'h00000000;
        rd_d[tcvs_ctl_flag_bit] = flag_q[i];
        rd_d[tcvs_ctl_ie_bit] = ie_q[i];
        rd_d[tcvs_ctl_mode_bit] = timer_in.capture_mode[i];
      end
    end
    wr_sts = access && pwrite && paddr == tcvs_off_status;
    wr_ist = access && pwrite && paddr == tcvs_off_irq_status;
    wr_imk = access && pwrite && paddr == tcvs_off_irq_mask;
    if (paddr == tcvs_off_status) begin
      mapped = 1'b1;
      rd_d = 32'h00000000;
      rd_d[tcvs_nch-1:0] = flag_q;
      rd_d[tcvs_sts_ovf_bit] = timer_in.counter_overflow_flag;
    end
    if (paddr == tcvs_off_irq_status) begin
      mapped = 1'b1;
      rd_d = {26'h0, istat_q};
    end
    if (paddr == tcvs_off_irq_mask) begin
      mapped = 1'b1;
      rd_d = {26'h0, imask_q};
    end
  end

  // clear requests: per-channel control write of one, or status write of all ones
  always_comb begin
    for (int i = 0; i < tcvs_nch; i++) begin
      clr_req[i] = (wr_ctl[i] && pwdata[tcvs_ctl_flag_bit]) ||
                   (wr_sts && pwdata == tcvs_all_ones);
    end
  end

  assign flag_rise = flag_q & ~flag_prev_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= access && !mapped;
      prdata <= (access && !pwrite) ? rd_d : 32'h00000000;
    end
  end

  // value registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < tcvs_nch; i++) begin
        active_q[i] <= tcvs_val_rst;
        buffer_q[i] <= tcvs_val_rst;
      end
      pend_q <= '0;
    end else begin
      for (int i = 0; i < tcvs_nch; i++) begin
        if (timer_in.capture_mode[i]) begin
          pend_q[i] <= 1'b0;
          if (timer_in.event_pulse[i]) begin
            active_q[i] <= timer_in.captured_value[i*16 +: 16];
          end
        end else begin
          // partial-lane writes dropped so the value never tears
          if (wr_val[i] && pstrb[1:0] == 2'b11) begin
            buffer_q[i] <= pwdata[15:0];
            pend_q[i] <= 1'b1;
          end else if (timer_in.update_point[i] && pend_q[i]) begin
            pend_q[i] <= 1'b0;
          end
          if (timer_in.update_point[i] && pend_q[i]) begin
            active_q[i] <= buffer_q[i];
          end
        end
      end
    end
  end

  // event flags and enables; set beats clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= '0;
      ie_q <= '0;
    end else begin
      for (int i = 0; i < tcvs_nch; i++) begin
        if (timer_in.event_pulse[i]) begin
          flag_q[i] <= 1'b1;
        end else if (clr_req[i]) begin
          flag_q[i] <= 1'b0;
        end
        if (wr_ctl[i]) begin
          ie_q[i] <= pwdata[tcvs_ctl_ie_bit];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      istat_q <= '0;
      imask_q <= '0;
      flag_prev_q <= '0;
      irq <= 1'b0;
      timer_out <= '0;
    end else begin
      flag_prev_q <= flag_q;
      for (int i = 0; i < tcvs_nch; i++) begin
        if (flag_rise[i]) begin
          istat_q[i] <= 1'b1;
        end else if (wr_ist && pwdata[i]) begin
          istat_q[i] <= 1'b0;
        end
        timer_out.active_value[i*16 +: 16] <= active_q[i];
      end
      if (wr_imk) begin
        imask_q <= pwdata[tcvs_nch-1:0];
      end
      timer_out.channel_irq <= flag_q & ie_q;
      irq <= |(istat_q & imask_q);
    end
  end
endmodule : tcvs_top
`default_nettype wire

// [pkg/tcvs_pkg.sv]
// package for the timer channel value and status block
// assumes an apb slave with 32-bit data; one word per register
// Contract
// - value register holds capture value in input modes, match value in compare modes
// - software writes to a value register are dropped in input capture mode
// - compare-mode writes go to a buffer, copied to active value at update point
// - channel value registers sit at 10h plus 8 times channel index, 0..5
// - value in bits 15..0, bits 31..16 read zero and ignore writes
// - status at 50h mirrors all channel event flags and counter overflow flag
// - writing all ones to status clears every channel event flag at once
// - channel event flag sets on capture or compare match event
// - event flag clears only on writing one, zero has no effect
// - new event racing a clear write wins, flag stays set
// - racing clear suppressed so channel interrupt request stays asserted
// - status bit 8 reads one when the counter has overflowed
// - status bits 5..0 mirror channel flags, bits 7..6 read zero
// - status bits 31..9 read zero and ignore writes
// - control register: flag bit 7, irq enable bit 6, request while both set
package tcvs_pkg;
  localparam int tcvs_nch = 6;
  localparam logic [11:0] tcvs_off_value0 = 12'h010;
  localparam logic [11:0] tcvs_off_value_step = 12'h008;
  localparam logic [11:0] tcvs_off_status = 12'h050;
  localparam logic [11:0] tcvs_off_ctrl0 = 12'h014;
  localparam logic [11:0] tcvs_off_irq_status = 12'h060;
  localparam logic [11:0] tcvs_off_irq_mask = 12'h064;
  localparam int tcvs_val_w = 16;
  localparam int tcvs_ctl_flag_bit = 7;
  localparam int tcvs_ctl_ie_bit = 6;
  localparam int tcvs_ctl_mode_bit = 0;
  localparam int tcvs_sts_ovf_bit = 8;
  localparam logic [15:0] tcvs_val_rst = 16'h0000;
  localparam logic [31:0] tcvs_all_ones = 32'hffffffff;

  typedef struct packed {
    logic [tcvs_nch-1:0] capture_mode;
    logic [tcvs_nch-1:0] event_pulse;
    logic [tcvs_nch-1:0] update_point;
    logic [tcvs_nch*16-1:0] captured_value;
    logic counter_overflow_flag;
  } tcvs_timer_in_t;

  typedef struct packed {
    logic [tcvs_nch*16-1:0] active_value;
    logic [tcvs_nch-1:0] channel_irq;
  } tcvs_timer_out_t;
endpackage : tcvs_pkg

// [verification/tcvs_checker.sv]
// assertions on the ports of the channel value and status block
// assumes it is bound to tcvs_top
`timescale 1ns/1ps
`default_nettype none
module tcvs_checker (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire tcvs_pkg::tcvs_timer_in_t timer_in,
  input wire tcvs_pkg::tcvs_timer_out_t timer_out
);
  import tcvs_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic rd_q = pready && !pwrite;
  ////////////////////////////////////////
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after one wait");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  AST_VAL_UPPER: assert property (rd_q && paddr[11:6] == 6'h0 && paddr[2:0] == 3'h0 && paddr[5:4] != 2'h0 |-> prdata[31:16] == 16'h0)
    else $error("value upper bits set");
  AST_STS_RSVD: assert property (rd_q && paddr == 12'h050 |-> prdata[31:9] == 23'h0 && prdata[7:6] == 2'h0)
    else $error("status reserved bits set");
  AST_OVF_LIVE: assert property (rd_q && paddr == 12'h050 && $stable(timer_in.counter_overflow_flag) |-> prdata[8] == timer_in.counter_overflow_flag)
    else $error("overflow bit wrong");
  AST_IRQ_KEPT: assert property (timer_in.event_pulse[0] && timer_out.channel_irq[0] && !(psel && pwrite && paddr != 12'h050) |=> ##1 timer_out.channel_irq[0])
    else $error("channel request lost");
endmodule : tcvs_checker
`default_nettype wire

// [verification/tcvs_top_tb.sv]
// self-checking bench for tcvs_top
// assumes apb answers with one wait state
`timescale 1ns/1ps
`default_nettype none
module tcvs_top_tb;
  import tcvs_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'h0;
  tcvs_timer_in_t ti = '0;
  tcvs_timer_out_t tout;
  int miscompares = 0, check_count = 0;
  always #12.5 mclk = ~mclk;
  tcvs_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_in(ti), .timer_out(tout), .irq(irq));
  ////////////////////////////////////////
  task automatic chk(input logic [11:0] a, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      $display("CHECK FAILED item %h exp %h got %h", a, x, g);
      miscompares++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(a, x, r);
  endtask : rd
  task automatic pulse(input logic [5:0] e, input logic [5:0] u);
    @(posedge mclk);
    ti.event_pulse <= e;
    ti.update_point <= u;
    @(posedge mclk);
    ti.event_pulse <= 6'h0;
    ti.update_point <= 6'h0;
  endtask : pulse
  task automatic t_cmp;
    logic [11:0] a;
    for (int i = 0; i < tcvs_nch; i++) begin
      a = 12'h010 + 12'(8 * i);
      wr(a, 32'h5a5ac300 + 32'(i));
      apb(1'b1, a, 32'h0, 4'h1);
      rd(a, {16'h0, tcvs_val_rst});
      pulse(6'h0, 6'(1 << i));
      rd(a, 32'hc300 + 32'(i));
      chk(a, 32'hc300 + 32'(i), {16'h0, tout.active_value[i*16+:16]});
    end
  endtask : t_cmp
  task automatic t_cap;
    @(posedge mclk);
    ti.capture_mode <= 6'h01;
    ti.captured_value[15:0] <= 16'h1234;
    ti.counter_overflow_flag <= 1'b1;
    pulse(6'h01, 6'h0);
    rd(12'h010, 32'h1234);
    wr(12'h010, 32'hffff);
    rd(12'h010, 32'h1234);
    rd(12'h050, 32'h101);
    apb(1'b0, 12'h0fc, 32'h0, 4'h0);
    chk(12'h0fc, 32'h1, {31'h0, err});
  endtask : t_cap
  task automatic t_flag;
    wr(12'h050, 32'h1);
    rd(12'h050, 32'h101);
    wr(12'h014, 32'h40);
    rd(12'h014, 32'hc1);
    wr(12'h064, 32'h1);
    @(posedge mclk);
    chk(12'h064, 32'h1, {31'h0, irq});
    chk(12'h014, 32'h1, {31'h0, tout.channel_irq[0]});
    wr(12'h050, tcvs_all_ones);
    rd(12'h050, 32'h100);
    wr(12'h064, 32'h0);
    wr(12'h060, 32'h1);
    wr(12'h064, 32'h1);
    @(posedge mclk);
    chk(12'h060, 32'h0, {31'h0, irq});
  endtask : t_flag
  task automatic t_race;
    pulse(6'h01, 6'h0);
    // the event lands on the same edge as the clearing access phase
    fork
      wr(12'h050, tcvs_all_ones);
      begin
        @(posedge mclk);
        pulse(6'h01, 6'h0);
      end
    join
    rd(12'h050, 32'h101);
    pulse(6'h01, 6'h0);
    wr(12'h014, 32'hc0);
    rd(12'h014, 32'h41);
  endtask : t_race
  task automatic tally_and_finish;
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    t_cmp();
    t_cap();
    t_flag();
    t_race();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end
endmodule : tcvs_top_tb
bind tcvs_top tcvs_checker chk_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_in(timer_in), .timer_out(timer_out));
`default_nettype wire
